/* File: rtl/ircs_pkg.sv */
// constants, types and state records for the idle/run clock switcher
package ircs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (8-bit registers, 4-bit address)
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_SEC_CTRL = 4'h1;

  // oscillator control register fields
  localparam int CTRL_IDLE_BIT = 7;
  localparam int CTRL_IFS_LSB = 4;
  localparam int CTRL_PRI_RDY_BIT = 3;
  localparam int CTRL_INT_STB_BIT = 2;
  localparam int CTRL_SCS_HI_BIT = 1;
  localparam int CTRL_SCS_LO_BIT = 0;

  // secondary oscillator control register fields
  localparam int SECONDARY_RUN_MODE_FLAG_BIT = 6;
  localparam int SEC_OSC_EN_BIT = 3;

  localparam logic [7:0] RESET_OSC_CTRL = 8'h00;
  localparam logic [7:0] RESET_SEC_CTRL = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // clock source encodings
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INT_FAST = 2'h2;
  localparam logic [1:0] SEL_INT_SLOW = 2'h3;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_DELAY_NS = 10000;
  localparam int STAB_TIME_NS = 1000000;
  localparam int WAKE_CYCLES_I = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_CYCLES_I = STAB_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] WAKE_CYCLES = WAKE_CYCLES_I[15:0];
  localparam logic [15:0] STAB_CYCLES = STAB_CYCLES_I[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_PRIMARY_RUN = 3'h0,
    ST_IDLE = 3'h1,
    ST_WAKE_DELAY = 3'h3,
    ST_ALT_RUN = 3'h2,
    ST_SWITCH_BACK = 3'h6
  } ircs_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ircs_reg_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] cnt;
  } ircs_tmr_s;

  typedef struct packed {
    ircs_state_e st;
    logic idle_on_sleep_bit;
    logic [1:0] clock_select_field;
    logic [2:0] internal_freq_select;
    logic secondary_osc_enable;
    logic primary_ready_flag;
    logic secondary_running_flag;
    logic internal_stable_flag;
    logic waking;
    logic src_sec;
    logic [1:0] sync_pri;
    logic [1:0] sync_sec;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic [1:0] sys_clk_sel;
    logic primary_osc_en;
    logic fast_en;
    logic slow_rc_en;
    logic [7:0] rdata;
  } ircs_state_s;

endpackage

/* File: rtl/ircs_timer.sv */
// one-shot delay counter with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none

module ircs_timer #(
  parameter logic [15:0] COUNT = 16'h00c8
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic clear_in,
  output logic done_out
);

  ircs_pkg::ircs_tmr_s q_r;
  ircs_pkg::ircs_tmr_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    if (clear_in) begin
      q_nxt.busy = 1'b0;
    end else if (start_in) begin
      q_nxt.busy = 1'b1;
      q_nxt.cnt = COUNT - 16'h0001;
    end else if (q_r.busy) begin
      if (q_r.cnt == 16'h0000) begin
        q_nxt.busy = 1'b0;
        q_nxt.done = 1'b1;
      end else begin
        q_nxt.cnt = q_r.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign done_out = q_r.done;

endmodule

`default_nettype wire

/* File: rtl/ircs_top.sv */
// clock mode controller: primary, secondary and internal sources with idle/run modes
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - idle bit set, select field 01 and a sleep stop the cpu while peripherals run on the secondary oscillator.
// - switching to the secondary oscillator stops the primary, clears primary-ready and sets secondary-running.
// - a write setting the low select bit while the secondary oscillator is disabled leaves that bit unchanged.
// - peripheral clocks wait while the secondary oscillator is the system clock source but not yet oscillating.
// - after a secondary-idle wake the cpu restarts on the secondary clock 10 us later and runs there until primary is ready.
// - once primary is ready the clock switches back, clearing secondary-running and setting primary-ready.
// - a wake-up changes neither the idle bit nor the select bits, and the secondary oscillator keeps running.
// - idle bit and high select bit with a sleep halt the cpu, clock peripherals internally and stop the primary.
// - a non-zero internal frequency select enables the fast internal output and sets internal-stable about 1 ms later.
// - internal-stable stays set through every mode change except the switch back to primary from an internal source.
// - an all-zero internal frequency select disables the fast output, clears internal-stable and runs from the slow rc.
// - after an internal-idle wake the cpu restarts internally 10 us later, then switches to primary when ready.
// - idle bit clear and high select bit with a sleep run cpu and peripherals internally and stop the primary.
// - in internal run mode a new internal frequency select changes the system clock at once.
// - a wake in internal run mode starts the primary and switches to it when ready, clearing internal-stable.
module ircs_top #(
  parameter logic [15:0] STAB_CYCLES = ircs_pkg::STAB_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire ircs_pkg::ircs_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sleep_exec_in,
  input wire logic wake_event_in,
  input wire logic primary_osc_ready_in,
  input wire logic secondary_osc_running_in,
  input wire logic watchdog_unit_en_in,
  input wire logic fail_safe_en_in,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic [1:0] sys_clk_sel_out,
  output logic primary_osc_en_out,
  output logic internal_fast_osc_en_out,
  output logic internal_slow_rc_en_out,
  output logic secondary_osc_enable_out,
  output logic [2:0] internal_freq_select_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  ircs_pkg::ircs_state_s q_r;
  ircs_pkg::ircs_state_s q_nxt;
  logic wake_go;
  logic wake_done;
  logic stab_go;
  logic stab_kill;
  logic stab_done;
  logic pri_rdy;
  logic sec_osc_up;
  logic wr_ctrl;
  logic wr_sec;

  assign pri_rdy = q_r.sync_pri[1];
  assign sec_osc_up = q_r.sync_sec[1];
  assign wr_ctrl = reg_req_in.wr && (reg_req_in.addr == ircs_pkg::ADDR_OSC_CTRL);
  assign wr_sec = reg_req_in.wr && (reg_req_in.addr == ircs_pkg::ADDR_SEC_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // delay timers

  // restart delay counts from the wake event itself
  assign wake_go = (q_r.st == ircs_pkg::ST_IDLE) && wake_event_in;
  // stabilisation starts when the select leaves zero, dies when it returns
  // the start is taken from the write itself: fast_en moves on the same edge as the select
  assign stab_go = wr_ctrl && (reg_req_in.wdata[ircs_pkg::CTRL_IFS_LSB +: 3] != 3'h0) &&
                   (q_r.internal_freq_select == 3'h0);
  assign stab_kill = (q_r.internal_freq_select == 3'h0) && !stab_go;

  ircs_timer #(
    .COUNT(ircs_pkg::WAKE_CYCLES)
  ) u_wake_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(wake_go),
    .clear_in(1'b0),
    .done_out(wake_done)
  );

  ircs_timer #(
    .COUNT(STAB_CYCLES)
  ) u_stab_timer (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(stab_go),
    .clear_in(stab_kill),
    .done_out(stab_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    q_nxt = q_r;
    q_nxt.sync_pri = {q_r.sync_pri[0], primary_osc_ready_in};
    q_nxt.sync_sec = {q_r.sync_sec[0], secondary_osc_running_in};
    q_nxt.rdata = 8'h00;

    // software writes; wake-ups never touch these fields
    if (wr_ctrl) begin
      q_nxt.idle_on_sleep_bit = reg_req_in.wdata[ircs_pkg::CTRL_IDLE_BIT];
      q_nxt.internal_freq_select = reg_req_in.wdata[ircs_pkg::CTRL_IFS_LSB +: 3];
      q_nxt.clock_select_field[1] = reg_req_in.wdata[ircs_pkg::CTRL_SCS_HI_BIT];
      if (!(reg_req_in.wdata[ircs_pkg::CTRL_SCS_LO_BIT] && !q_r.secondary_osc_enable)) begin
        q_nxt.clock_select_field[0] = reg_req_in.wdata[ircs_pkg::CTRL_SCS_LO_BIT];
      end
    end
    if (wr_sec) begin
      q_nxt.secondary_osc_enable = reg_req_in.wdata[ircs_pkg::SEC_OSC_EN_BIT];
    end

    if (reg_req_in.rd) begin
      if (reg_req_in.addr == ircs_pkg::ADDR_OSC_CTRL) begin
        q_nxt.rdata = {q_r.idle_on_sleep_bit, q_r.internal_freq_select, q_r.primary_ready_flag,
                       q_r.internal_stable_flag, q_r.clock_select_field};
      end else if (reg_req_in.addr == ircs_pkg::ADDR_SEC_CTRL) begin
        q_nxt.rdata = {1'b0, q_r.secondary_running_flag, 2'h0, q_r.secondary_osc_enable, 3'h0};
      end
    end

    unique case (q_r.st)
      ircs_pkg::ST_PRIMARY_RUN: begin
        q_nxt.primary_osc_en = 1'b1;
        q_nxt.primary_ready_flag = pri_rdy;
        // sleep with select 00 is plain primary sleep, handled elsewhere
        if (sleep_exec_in && (q_r.clock_select_field != 2'h0)) begin
          q_nxt.src_sec = (q_r.clock_select_field == ircs_pkg::SCS_SECONDARY);
          q_nxt.primary_osc_en = 1'b0;
          q_nxt.primary_ready_flag = 1'b0;
          q_nxt.waking = 1'b0;
          if (q_nxt.src_sec) begin
            q_nxt.secondary_running_flag = 1'b1;
          end
          // idle bit picks cpu halt or cpu run on the alternate source
          q_nxt.st = q_r.idle_on_sleep_bit ? ircs_pkg::ST_IDLE : ircs_pkg::ST_ALT_RUN;
        end
      end
      ircs_pkg::ST_IDLE: begin
        if (wake_event_in) begin
          q_nxt.primary_osc_en = 1'b1;
          q_nxt.waking = 1'b1;
          q_nxt.st = ircs_pkg::ST_WAKE_DELAY;
        end
      end
      ircs_pkg::ST_WAKE_DELAY: begin
        if (wake_done) begin
          q_nxt.st = ircs_pkg::ST_ALT_RUN;
        end
      end
      ircs_pkg::ST_ALT_RUN: begin
        if (q_r.waking && pri_rdy) begin
          q_nxt.st = ircs_pkg::ST_SWITCH_BACK;
        end else if (!q_r.waking && wake_event_in) begin
          q_nxt.waking = 1'b1;
          q_nxt.primary_osc_en = 1'b1;
        end else if (!q_r.waking && sleep_exec_in && q_r.idle_on_sleep_bit) begin
          q_nxt.st = ircs_pkg::ST_IDLE;
        end
      end
      ircs_pkg::ST_SWITCH_BACK: begin
        q_nxt.secondary_running_flag = 1'b0;
        q_nxt.primary_ready_flag = 1'b1;
        if (!q_r.src_sec) begin
          q_nxt.internal_stable_flag = 1'b0;
        end
        q_nxt.waking = 1'b0;
        q_nxt.st = ircs_pkg::ST_PRIMARY_RUN;
      end
      default: begin
        q_nxt.st = ircs_pkg::ST_PRIMARY_RUN;
      end
    endcase

    // internal-stable follows the select; of the modes only the switch back from an internal source clears it
    if (q_r.internal_freq_select == 3'h0) begin
      q_nxt.internal_stable_flag = 1'b0;
    end
    if (stab_done && (q_r.internal_freq_select != 3'h0)) begin
      q_nxt.internal_stable_flag = 1'b1;
    end
    q_nxt.fast_en = (q_nxt.internal_freq_select != 3'h0);

    // source follows the select as soon as it is written
    if (q_nxt.st == ircs_pkg::ST_PRIMARY_RUN) begin
      q_nxt.sys_clk_sel = ircs_pkg::SEL_PRIMARY;
    end else if (q_nxt.src_sec) begin
      q_nxt.sys_clk_sel = ircs_pkg::SEL_SECONDARY;
    end else if (q_nxt.internal_freq_select != 3'h0) begin
      q_nxt.sys_clk_sel = ircs_pkg::SEL_INT_FAST;
    end else begin
      q_nxt.sys_clk_sel = ircs_pkg::SEL_INT_SLOW;
    end

    // an unstarted secondary crystal would feed runt clocks downstream
    q_nxt.periph_clk_en = !((q_nxt.st != ircs_pkg::ST_PRIMARY_RUN) && q_nxt.src_sec && !sec_osc_up);
    q_nxt.cpu_clk_en = q_nxt.periph_clk_en && (q_nxt.st != ircs_pkg::ST_IDLE) &&
                       (q_nxt.st != ircs_pkg::ST_WAKE_DELAY);
    q_nxt.slow_rc_en = (q_nxt.sys_clk_sel == ircs_pkg::SEL_INT_SLOW) || watchdog_unit_en_in ||
                       fail_safe_en_in;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
      q_r.st <= ircs_pkg::ST_PRIMARY_RUN;
      q_r.cpu_clk_en <= 1'b1;
      q_r.periph_clk_en <= 1'b1;
      q_r.primary_osc_en <= 1'b1;
      q_r.slow_rc_en <= 1'b1;
      q_r.sys_clk_sel <= ircs_pkg::SEL_PRIMARY;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = q_r.rdata;
  assign cpu_clk_en_out = q_r.cpu_clk_en;
  assign periph_clk_en_out = q_r.periph_clk_en;
  assign sys_clk_sel_out = q_r.sys_clk_sel;
  assign primary_osc_en_out = q_r.primary_osc_en;
  assign internal_fast_osc_en_out = q_r.fast_en;
  assign internal_slow_rc_en_out = q_r.slow_rc_en;
  assign secondary_osc_enable_out = q_r.secondary_osc_enable;
  assign internal_freq_select_out = q_r.internal_freq_select;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int A_WAKE_LO = 200;
  localparam int A_WAKE_HI = 204;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_secondary_idle_mode_entry: assert property (
    (q_r.st == ircs_pkg::ST_PRIMARY_RUN) && sleep_exec_in && q_r.idle_on_sleep_bit &&
    (q_r.clock_select_field == 2'h1)
    |=> (q_r.st == ircs_pkg::ST_IDLE) && !cpu_clk_en_out && (sys_clk_sel_out == ircs_pkg::SEL_SECONDARY))
    else $error("secondary idle entry wrong");

  a_sec_switch_flags: assert property (
    (q_r.st == ircs_pkg::ST_PRIMARY_RUN) && sleep_exec_in && (q_r.clock_select_field == 2'h1)
    |=> !primary_osc_en_out && !q_r.primary_ready_flag && q_r.secondary_running_flag)
    else $error("secondary switch flags wrong");

  a_sel_low_block: assert property (
    wr_ctrl && reg_req_in.wdata[0] && !q_r.secondary_osc_enable && !q_r.clock_select_field[0]
    |=> !q_r.clock_select_field[0])
    else $error("low select bit set without secondary enable");

  a_periph_hold: assert property (
    (q_r.st == ircs_pkg::ST_IDLE) && q_r.src_sec && !sec_osc_up && !wake_event_in
    |=> !periph_clk_en_out)
    else $error("peripheral clock ran before secondary started");

  a_wake_cpu_hold: assert property (
    (q_r.st == ircs_pkg::ST_IDLE) && wake_event_in |=> !cpu_clk_en_out [*8])
    else $error("cpu restarted too early");

  a_wake_resume: assert property (
    (q_r.st == ircs_pkg::ST_IDLE) && wake_event_in
    |-> ##[A_WAKE_LO:A_WAKE_HI] (q_r.st == ircs_pkg::ST_ALT_RUN))
    else $error("cpu restart delay wrong");

  a_switch_flags: assert property (
    (q_r.st == ircs_pkg::ST_SWITCH_BACK)
    |=> q_r.primary_ready_flag && !q_r.secondary_running_flag &&
        (sys_clk_sel_out == ircs_pkg::SEL_PRIMARY))
    else $error("switch back flags wrong");

  a_wake_keeps_ctrl: assert property (
    (q_r.st == ircs_pkg::ST_IDLE) && wake_event_in && !reg_req_in.wr
    |=> $stable(q_r.idle_on_sleep_bit) && $stable(q_r.clock_select_field))
    else $error("wake altered control bits");

  a_int_idle_entry: assert property (
    (q_r.st == ircs_pkg::ST_PRIMARY_RUN) && sleep_exec_in && q_r.idle_on_sleep_bit &&
    q_r.clock_select_field[1]
    |=> (q_r.st == ircs_pkg::ST_IDLE) && !q_r.src_sec && !primary_osc_en_out && !q_r.primary_ready_flag)
    else $error("internal idle entry wrong");

  a_ifs_zero: assert property (
    (q_r.internal_freq_select == 3'h0) |=> !q_r.internal_stable_flag)
    else $error("internal stable set with zero select");

  a_run_freq_now: assert property (
    (q_r.st == ircs_pkg::ST_ALT_RUN) && !q_r.src_sec
    |-> sys_clk_sel_out == ((q_r.internal_freq_select != 3'h0) ? ircs_pkg::SEL_INT_FAST :
                                                                 ircs_pkg::SEL_INT_SLOW))
    else $error("internal run clock not following select");

  a_slow_rc_keep: assert property (
    watchdog_unit_en_in || fail_safe_en_in |=> internal_slow_rc_en_out)
    else $error("slow rc stopped while watchdog or monitor enabled");

  a_fast_enable: assert property (
    wr_ctrl && (reg_req_in.wdata[ircs_pkg::CTRL_IFS_LSB +: 3] != 3'h0) && (q_r.internal_freq_select == 3'h0)
    |=> internal_fast_osc_en_out && !q_r.internal_stable_flag)
    else $error("fast internal output not enabled on non-zero select");

  a_stable_keep: assert property (
    q_r.internal_stable_flag && (q_r.internal_freq_select != 3'h0) &&
    (q_r.st != ircs_pkg::ST_SWITCH_BACK) &&
    !(wr_ctrl && (reg_req_in.wdata[ircs_pkg::CTRL_IFS_LSB +: 3] == 3'h0))
    |=> q_r.internal_stable_flag)
    else $error("internal stable flag lost across a mode change");

  a_run_entry: assert property (
    (q_r.st == ircs_pkg::ST_PRIMARY_RUN) && sleep_exec_in && !q_r.idle_on_sleep_bit &&
    q_r.clock_select_field[1]
    |=> (q_r.st == ircs_pkg::ST_ALT_RUN) && cpu_clk_en_out && periph_clk_en_out &&
        !primary_osc_en_out && !q_r.primary_ready_flag)
    else $error("internal run entry wrong");

  a_run_wake_start: assert property (
    (q_r.st == ircs_pkg::ST_ALT_RUN) && !q_r.waking && !q_r.src_sec && wake_event_in
    |=> primary_osc_en_out && cpu_clk_en_out && (sys_clk_sel_out != ircs_pkg::SEL_PRIMARY))
    else $error("internal run wake did not start primary");

  a_int_switch_flags: assert property (
    (q_r.st == ircs_pkg::ST_SWITCH_BACK) && !q_r.src_sec && !stab_done
    |=> !q_r.internal_stable_flag && q_r.primary_ready_flag && (sys_clk_sel_out == ircs_pkg::SEL_PRIMARY))
    else $error("internal switch back flags wrong");

  c_secondary_idle_mode_wake: cover property (
    (q_r.st == ircs_pkg::ST_SWITCH_BACK) && q_r.src_sec);
  c_int_idle_wake: cover property (
    (q_r.st == ircs_pkg::ST_SWITCH_BACK) && !q_r.src_sec && q_r.internal_stable_flag);
  c_int_run_freq: cover property (
    (q_r.st == ircs_pkg::ST_ALT_RUN) && !q_r.waking && wr_ctrl);
  c_stab_done: cover property (stab_done);
  c_run_wake: cover property (
    (q_r.st == ircs_pkg::ST_ALT_RUN) && !q_r.waking && !q_r.src_sec && wake_event_in);

endmodule

`default_nettype wire

/* File: dv/ircs_top_test.sv */
// self-checking testbench for the idle/run clock switcher
`timescale 1ns/1ps
`default_nettype none

module ircs_top_test;
  // short stabilisation count keeps the run brief; expectations below follow it
  localparam logic [15:0] STAB_SIM = 16'h0014;
  localparam logic [3:0] A_CTRL = ircs_pkg::ADDR_OSC_CTRL;
  localparam logic [3:0] A_SEC = ircs_pkg::ADDR_SEC_CTRL;

  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  ircs_pkg::ircs_reg_req_s reg_req = '0;
  logic sleep_exec = 1'b0;
  logic wake_event = 1'b0;
  logic pri_ready = 1'b1;
  logic sec_running = 1'b0;
  logic wdt_en = 1'b0;
  logic fs_en = 1'b0;
  logic [7:0] reg_rdata;
  logic cpu_en;
  logic periph_en;
  logic pri_en;
  logic fast_en;
  logic slow_en;
  logic sec_en;
  logic [1:0] clk_sel;
  logic [2:0] freq_sel;
  int fails = 0;
  int n_compared = 0;

  ircs_top #(.STAB_CYCLES(STAB_SIM)) dut (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .reg_req_in(reg_req),
    .reg_rdata_out(reg_rdata),
    .sleep_exec_in(sleep_exec),
    .wake_event_in(wake_event),
    .primary_osc_ready_in(pri_ready),
    .secondary_osc_running_in(sec_running),
    .watchdog_unit_en_in(wdt_en),
    .fail_safe_en_in(fs_en),
    .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(periph_en),
    .sys_clk_sel_out(clk_sel),
    .primary_osc_en_out(pri_en),
    .internal_fast_osc_en_out(fast_en),
    .internal_slow_rc_en_out(slow_en),
    .secondary_osc_enable_out(sec_en),
    .internal_freq_select_out(freq_sel)
  );

  always #25 clk_sys_in = ~clk_sys_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every task except chk_val and stop_test is entered just after a rising edge and returns on one
  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    reg_req <= {1'b1, 1'b0, addr, data};
    @(posedge clk_sys_in);
    reg_req <= '0;
    // one idle edge so the next request never re-drives the bus in this time step
    @(posedge clk_sys_in);
  endtask

  task automatic chk_reg(input logic [3:0] addr, input logic [7:0] exp);
    reg_req <= {1'b0, 1'b1, addr, 8'h00};
    @(posedge clk_sys_in);
    reg_req <= '0;
    @(negedge clk_sys_in);
    chk_val($sformatf("reg %h", addr), exp, reg_rdata);
    @(posedge clk_sys_in);
  endtask

  // packed as {cpu, periph, primary en, fast en, slow en, sel[1:0]}
  task automatic chk_ports(input string what, input logic [6:0] exp);
    @(negedge clk_sys_in);
    chk_val(what, {1'b0, exp}, {1'b0, cpu_en, periph_en, pri_en, fast_en, slow_en, clk_sel});
    @(posedge clk_sys_in);
  endtask

  task automatic pulse(input bit is_wake);
    if (is_wake) begin
      wake_event <= 1'b1;
    end else begin
      sleep_exec <= 1'b1;
    end
    @(posedge clk_sys_in);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
  endtask

  // which 0 watches the cpu enable, 1 the clock select; n counts cycles
  task automatic wait_for(input string what, input int which, input logic [1:0] v, input int lo, input int hi);
    int n;
    bit seen;
    logic [1:0] cur;
    n = 0;
    seen = 1'b0;
    while (!seen && (n <= hi)) begin
      @(negedge clk_sys_in);
      n++;
      cur = (which == 0) ? {1'b0, cpu_en} : clk_sel;
      seen = (cur === v);
    end
    if (!seen) begin
      fails++;
      $display("[ERR] %s expected %h seen timeout", what, v);
      stop_test();
    end else begin
      chk_val(what, 8'h01, {7'h00, (n >= lo) && (n <= hi)});
      @(posedge clk_sys_in);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk_ports("reset levels", 7'h70);
    chk_reg(A_CTRL, 8'h08);
    chk_reg(A_SEC, 8'h00);
    $display("test reset done");

    reg_write(A_CTRL, 8'h01);
    chk_reg(A_CTRL, 8'h08);
    reg_write(A_SEC, 8'h48);
    chk_reg(A_SEC, 8'h08);
    reg_write(A_CTRL, 8'h81);
    chk_reg(A_CTRL, 8'h89);
    chk_reg(4'h5, 8'h00);
    chk_val("sec enable out", 8'h01, {7'h00, sec_en});
    $display("test select guard done");

    // secondary oscillator not yet oscillating: peripherals must wait
    pulse(1'b0);
    chk_ports("secondary_idle_mode entry", 7'h01);
    pri_ready <= 1'b0;
    chk_reg(A_SEC, 8'h48);
    chk_reg(A_CTRL, 8'h81);
    sec_running <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_ports("secondary_idle_mode running", 7'h21);
    pulse(1'b1);
    wait_for("sec cpu restart", 0, 2'h1, 200, 206);
    repeat (10) @(posedge clk_sys_in);
    chk_ports("secondary_run_mode", 7'h71);
    pri_ready <= 1'b1;
    wait_for("sec switch back", 1, 2'h0, 2, 8);
    chk_reg(A_CTRL, 8'h89);
    chk_reg(A_SEC, 8'h08);
    chk_val("sec enable kept", 8'h01, {7'h00, sec_en});
    $display("test secondary idle done");

    reg_write(A_CTRL, 8'h92);
    chk_ports("fast enabled", 7'h78);
    chk_val("freq out", 8'h01, {5'h00, freq_sel});
    repeat (10) @(posedge clk_sys_in);
    chk_reg(A_CTRL, 8'h9a);
    repeat (10) @(posedge clk_sys_in);
    chk_reg(A_CTRL, 8'h9e);
    wdt_en <= 1'b1;
    pulse(1'b0);
    chk_ports("int idle entry", 7'h2e);
    pri_ready <= 1'b0;
    chk_reg(A_CTRL, 8'h96);
    pulse(1'b1);
    wait_for("int cpu restart", 0, 2'h1, 200, 206);
    chk_ports("int run after wake", 7'h7e);
    pri_ready <= 1'b1;
    wait_for("int switch back", 1, 2'h0, 2, 8);
    chk_reg(A_CTRL, 8'h9a);
    wdt_en <= 1'b0;
    fs_en <= 1'b1;
    $display("test internal idle done");

    reg_write(A_CTRL, 8'h02);
    chk_reg(A_CTRL, 8'h0a);
    chk_ports("fast disabled", 7'h74);
    // primary source is taken as an external oscillator here, never the internal block
    pulse(1'b0);
    chk_ports("int run entry", 7'h67);
    pri_ready <= 1'b0;
    chk_reg(A_CTRL, 8'h02);
    reg_write(A_CTRL, 8'h52);
    @(posedge clk_sys_in);
    chk_ports("freq change", 7'h6e);
    pulse(1'b1);
    chk_ports("primary restart", 7'h7e);
    pri_ready <= 1'b1;
    wait_for("run switch back", 1, 2'h0, 2, 8);
    chk_reg(A_CTRL, 8'h5a);
    $display("test internal run done");
    stop_test();
  end
endmodule

`default_nettype wire
